// ### verilog/isfm_top.sv
// input clock selection and fault monitoring with an AHB-Lite register slave
//
// Implementation choices: the register offsets and register access over AHB-Lite.
`timescale 1ns/10ps
module isfm_top
    import isfm_pkg::*;
(
    input wire logic CORE_CLK,
    input wire logic RSTN,
    input wire logic HSEL,
    input wire logic [31:0] HADDR,
    input wire logic [1:0] HTRANS,
    input wire logic HWRITE,
    input wire logic [2:0] HSIZE,
    input wire logic [31:0] HWDATA,
    input wire logic HREADY,
    output logic [31:0] HRDATA,
    output logic HREADYOUT,
    output logic HRESP,
    input wire logic [ISFM_NUM_IN-1:0] IN_CLK,
    input wire logic CRYSTAL_REFERENCE_INPUT,
    input wire logic [1:0] IN_SEL_PINS,
    input wire logic [ISFM_THR_W-1:0] LOCK_FREQ_DIFF,
    output logic [1:0] SEL_INPUT,
    output logic SEL_VALID,
    output logic HOLDOVER,
    output logic SWITCH_PULSE,
    output logic HITLESS_EN,
    output logic RAMP_EN,
    output logic OUT_CLK_EN,
    output logic LOCK_LOST_FLAG,
    output logic INTERRUPT_OUT_N
);
    isfm_cfg_t cfg_reg;
    logic [ISFM_NUM_MON+1:0] mon_dis_reg;
    logic [2*ISFM_PRIO_W+3:0] prio_reg;
    logic [ISFM_TOL_W*ISFM_NUM_IN-1:0] loss_sens_reg;
    logic [ISFM_WIN_W-1:0] fwin_reg;
    logic [ISFM_WIN_W-1:0] fhys_reg;
    logic [ISFM_THR_W-1:0] lset_reg;
    logic [ISFM_THR_W-1:0] lclr_reg;
    logic [ISFM_TMR_W-1:0] ltmr_reg;
    logic [ISFM_STAT_W-1:0] live_reg;
    logic [ISFM_STAT_W-1:0] sticky_reg;
    logic [ISFM_STAT_W-1:0] mask_reg;
    logic [1:0] sel_pin_s1_reg;
    logic [1:0] sel_pin_s2_reg;
    logic [11:0] win_cnt_reg;
    logic win_tick;
    logic win_tick_d_reg;
    logic [ISFM_NUM_MON-1:0] sig_loss;
    logic [ISFM_CNT_W-1:0] freq_cnt [ISFM_NUM_MON];
    logic [ISFM_CNT_W-1:0] ref_cnt;
    logic [ISFM_NUM_IN-1:0] prec_err_reg;
    logic [ISFM_NUM_IN-1:0] fast_err_reg;
    logic [ISFM_NUM_IN-1:0] ferr;
    logic [ISFM_NUM_IN-1:0] in_valid;
    isfm_state_t state_reg;
    isfm_state_t state_next;
    logic [1:0] sel_reg;
    logic [1:0] sel_next;
    logic tgt_ok;
    logic [2:0] best;
    logic [1:0] man_code;
    logic lol_reg;
    logic [ISFM_TMR_W-1:0] lol_tmr_reg;
    logic [ISFM_STAT_W-1:0] live_next;
    logic addr_wr_reg;
    logic addr_ok_reg;
    logic [5:0] addr_idx_reg;
    logic req;

    // per-clock monitors: four inputs plus the crystal reference
    for (genvar i = 0; i < ISFM_NUM_MON; i++)
    begin : g_mon
        logic [ISFM_TOL_W-1:0] tol;
        logic [ISFM_CNT_W-1:0] fc;
        if (i < ISFM_NUM_IN)
        begin : g_in
            logic [ISFM_TOL_W-1:0] t_raw;
            assign t_raw = loss_sens_reg[ISFM_TOL_W*i +: ISFM_TOL_W];
            // gapped clocks lose up to two of eight edges
            assign tol = (cfg_reg.gapped && t_raw < ISFM_GAP_TOL) ? ISFM_GAP_TOL : t_raw;
        end
        else
        begin : g_x
            assign tol = '0;
        end
        isfm_clk_mon u_mon (
            .clk(CORE_CLK),
            .rstn(RSTN),
            .clk_pin(i < ISFM_NUM_IN ? IN_CLK[i % ISFM_NUM_IN] : CRYSTAL_REFERENCE_INPUT),
            .mon_en(~mon_dis_reg[i]),
            .tol(tol),
            .win_tick(win_tick),
            .loss(sig_loss[i]),
            .freq_cnt(fc)
        );
        assign freq_cnt[i] = fc;
    end

    always_ff @(posedge CORE_CLK)
    begin
        if (!RSTN)
            win_cnt_reg <= '0;
        else
            win_cnt_reg <= win_cnt_reg + 1'b1;
    end
    assign win_tick = (win_cnt_reg == ISFM_WIN_LAST);

    // counts are latched on the tick, so comparisons run one cycle later
    always_ff @(posedge CORE_CLK)
    begin
        if (!RSTN)
            win_tick_d_reg <= 1'b0;
        else
            win_tick_d_reg <= win_tick;
    end

    // zero-ppm reference choice
    assign ref_cnt = (cfg_reg.ferr_ref == ISFM_REF_XTAL) ? freq_cnt[ISFM_XREF_IDX] :
        freq_cnt[cfg_reg.ferr_ref[1:0]];

    for (genvar i = 0; i < ISFM_NUM_IN; i++)
    begin : g_ferr
        logic [ISFM_CNT_W-1:0] prev_reg;
        logic [ISFM_PROD_W-1:0] lhs;
        logic [ISFM_PROD_W-1:0] hi;
        logic [ISFM_PROD_W-1:0] lo;
        logic [ISFM_PROD_W-1:0] fl;
        logic [ISFM_PROD_W-1:0] fr;
        logic [ISFM_WIN_W-1:0] win_lo;
        assign lhs = ISFM_PROD_W'(isfm_abs_diff(freq_cnt[i], ref_cnt)) * ISFM_PREC_SCALE;
        assign win_lo = (fhys_reg > fwin_reg) ? '0 : fwin_reg - fhys_reg;
        assign hi = ISFM_PROD_W'(fwin_reg) * ISFM_PROD_W'(ref_cnt);
        assign lo = ISFM_PROD_W'(win_lo) * ISFM_PROD_W'(ref_cnt);
        assign fl = ISFM_PROD_W'(isfm_abs_diff(freq_cnt[i], prev_reg)) * ISFM_FAST_SCALE;
        assign fr = ISFM_PROD_W'(prev_reg) * ISFM_FAST_LIM;
        always_ff @(posedge CORE_CLK)
        begin
            if (!RSTN)
            begin
                prev_reg <= '0;
                prec_err_reg[i] <= 1'b0;
                fast_err_reg[i] <= 1'b0;
            end
            else if (win_tick_d_reg)
            begin
                prev_reg <= freq_cnt[i];
                // set beyond the window, clear only inside window less hysteresis
                if (prec_err_reg[i])
                    prec_err_reg[i] <= (lhs > lo);
                else
                    prec_err_reg[i] <= (lhs > hi);
                fast_err_reg[i] <= (fl > fr);
            end
        end
        assign ferr[i] = (prec_err_reg[i] & ~mon_dis_reg[ISFM_MD_PREC]) |
            (fast_err_reg[i] & ~mon_dis_reg[ISFM_MD_FAST]);
        // input 3 is the feedback input in zero-delay mode
        assign in_valid[i] = ~sig_loss[i] & ~ferr[i] &
            ~(cfg_reg.zero_delay && i == ISFM_NUM_IN - 1);
    end

    always_ff @(posedge CORE_CLK)
    begin
        if (!RSTN)
        begin
            sel_pin_s1_reg <= 2'h0;
            sel_pin_s2_reg <= 2'h0;
        end
        else
        begin
            sel_pin_s1_reg <= IN_SEL_PINS;
            sel_pin_s2_reg <= sel_pin_s1_reg;
        end
    end

    assign man_code = cfg_reg.sel_from_reg ? cfg_reg.man_code : sel_pin_s2_reg;
    assign best = isfm_pick_best(in_valid, prio_reg);

    always_comb
    begin
        sel_next = sel_reg;
        tgt_ok = 1'b0;
        if (!cfg_reg.auto_mode)
        begin
            sel_next = man_code;
            // code 3 is reserved under zero delay, a silent input gives up
            tgt_ok = !(cfg_reg.zero_delay && man_code == ISFM_CODE_FB) && !sig_loss[man_code];
        end
        else if (!cfg_reg.revertive && state_reg == ISFM_LOCKED && in_valid[sel_reg])
        begin
            tgt_ok = 1'b1;
        end
        else
        begin
            sel_next = best[1:0];
            tgt_ok = best[2];
        end
    end

    always_comb
    begin
        case (state_reg)
            ISFM_FREERUN: state_next = tgt_ok ? ISFM_LOCKED : ISFM_FREERUN;
            ISFM_LOCKED: state_next = tgt_ok ? ISFM_LOCKED : ISFM_HOLDOVER;
            ISFM_HOLDOVER: state_next = tgt_ok ? ISFM_LOCKED : ISFM_HOLDOVER;
            default: state_next = ISFM_FREERUN;
        endcase
    end

    always_ff @(posedge CORE_CLK)
    begin
        if (!RSTN)
        begin
            state_reg <= ISFM_FREERUN;
            sel_reg <= 2'h0;
            SWITCH_PULSE <= 1'b0;
        end
        else
        begin
            state_reg <= state_next;
            if (tgt_ok)
                sel_reg <= sel_next;
            SWITCH_PULSE <= tgt_ok && (state_reg != ISFM_LOCKED || sel_next != sel_reg);
        end
    end

    always_ff @(posedge CORE_CLK)
    begin
        if (!RSTN)
        begin
            SEL_INPUT <= 2'h0;
            SEL_VALID <= 1'b0;
            HOLDOVER <= 1'b0;
            HITLESS_EN <= 1'b0;
            RAMP_EN <= 1'b0;
            OUT_CLK_EN <= 1'b0;
        end
        else
        begin
            SEL_INPUT <= sel_reg;
            SEL_VALID <= (state_reg == ISFM_LOCKED);
            HOLDOVER <= (state_reg == ISFM_HOLDOVER);
            // hitless is unavailable with zero delay
            HITLESS_EN <= cfg_reg.hitless & ~cfg_reg.zero_delay;
            RAMP_EN <= cfg_reg.ramp;
            OUT_CLK_EN <= ~sig_loss[ISFM_XREF_IDX] | cfg_reg.keep_out;
        end
    end

    // lock lost: set above the set threshold, or while not locked or switching
    always_ff @(posedge CORE_CLK)
    begin
        if (!RSTN)
        begin
            lol_reg <= 1'b1;
            lol_tmr_reg <= '0;
        end
        else if (LOCK_FREQ_DIFF > lset_reg || state_reg != ISFM_LOCKED || SWITCH_PULSE)
        begin
            lol_reg <= 1'b1;
            lol_tmr_reg <= '0;
        end
        else if (lol_reg && LOCK_FREQ_DIFF < lclr_reg)
        begin
            // a zero timer clears at once
            if (lol_tmr_reg >= ltmr_reg)
                lol_reg <= 1'b0;
            else
                lol_tmr_reg <= lol_tmr_reg + 1'b1;
        end
        else
            lol_tmr_reg <= '0;
    end

    always_comb
    begin
        live_next = '0;
        live_next[ISFM_S_LOSS +: ISFM_NUM_IN] = sig_loss[ISFM_NUM_IN-1:0];
        live_next[ISFM_S_XLOSS] = sig_loss[ISFM_XREF_IDX];
        live_next[ISFM_S_FERR +: ISFM_NUM_IN] = ferr;
        live_next[ISFM_S_LOL] = lol_reg;
        live_next[ISFM_S_HOLD] = (state_reg == ISFM_HOLDOVER);
    end

    // address phase is latched; the zero-wait data phase uses it
    assign req = HSEL & HREADY & HTRANS[1];

    always_ff @(posedge CORE_CLK)
    begin
        if (!RSTN)
        begin
            addr_wr_reg <= 1'b0;
            addr_ok_reg <= 1'b0;
            addr_idx_reg <= '0;
        end
        else if (HREADY)
        begin
            addr_wr_reg <= req & HWRITE;
            addr_ok_reg <= req & (HADDR[31:8] == 24'h000000);
            addr_idx_reg <= HADDR[7:2];
        end
    end

    always_ff @(posedge CORE_CLK)
    begin
        if (!RSTN)
        begin
            live_reg <= '0;
            sticky_reg <= '0;
        end
        else
        begin
            live_reg <= live_next;
            // a live condition in the clearing cycle keeps the bit set
            if (addr_wr_reg && addr_ok_reg && addr_idx_reg == ISFM_R_STICKY)
                sticky_reg <= (sticky_reg & ~HWDATA[ISFM_STAT_W-1:0]) | live_next;
            else
                sticky_reg <= sticky_reg | live_next;
        end
    end

    always_ff @(posedge CORE_CLK)
    begin
        if (!RSTN)
        begin
            cfg_reg <= '0;
            mon_dis_reg <= '0;
            prio_reg <= ISFM_PRIO_RST;
            loss_sens_reg <= '0;
            fwin_reg <= '0;
            fhys_reg <= '0;
            lset_reg <= '0;
            lclr_reg <= '0;
            ltmr_reg <= '0;
            mask_reg <= '0;
        end
        else if (addr_wr_reg && addr_ok_reg)
        begin
            case (addr_idx_reg)
                ISFM_R_CTRL: cfg_reg <= isfm_cfg_t'(HWDATA[$bits(isfm_cfg_t)-1:0]);
                ISFM_R_MONDIS: mon_dis_reg <= HWDATA[ISFM_NUM_MON+1:0];
                ISFM_R_PRIO: prio_reg <= HWDATA[2*ISFM_PRIO_W+3:0];
                ISFM_R_LOSSENS: loss_sens_reg <= HWDATA[ISFM_TOL_W*ISFM_NUM_IN-1:0];
                ISFM_R_FWIN:
                begin
                    fwin_reg <= HWDATA[ISFM_WIN_W-1:0];
                    fhys_reg <= HWDATA[ISFM_FW_HYS +: ISFM_WIN_W];
                end
                ISFM_R_LSET: lset_reg <= HWDATA[ISFM_THR_W-1:0];
                ISFM_R_LCLR: lclr_reg <= HWDATA[ISFM_THR_W-1:0];
                ISFM_R_LTMR: ltmr_reg <= HWDATA[ISFM_TMR_W-1:0];
                ISFM_R_MASK: mask_reg <= HWDATA[ISFM_STAT_W-1:0];
                default: mask_reg <= mask_reg;
            endcase
        end
    end

    always_ff @(posedge CORE_CLK)
    begin
        if (!RSTN)
            HRDATA <= '0;
        else if (req && !HWRITE && HADDR[31:8] == 24'h000000)
        begin
            case (HADDR[7:2])
                ISFM_R_CTRL: HRDATA <= 32'(cfg_reg);
                ISFM_R_MONDIS: HRDATA <= 32'(mon_dis_reg);
                ISFM_R_PRIO: HRDATA <= 32'(prio_reg);
                ISFM_R_LOSSENS: HRDATA <= 32'(loss_sens_reg);
                ISFM_R_FWIN: HRDATA <= 32'({3'h0, fhys_reg, 3'h0, fwin_reg});
                ISFM_R_LSET: HRDATA <= 32'(lset_reg);
                ISFM_R_LCLR: HRDATA <= 32'(lclr_reg);
                ISFM_R_LTMR: HRDATA <= 32'(ltmr_reg);
                ISFM_R_LIVE: HRDATA <= 32'({SEL_VALID, sel_reg, 1'b0, live_reg});
                ISFM_R_STICKY: HRDATA <= 32'(sticky_reg);
                ISFM_R_MASK: HRDATA <= 32'(mask_reg);
                default: HRDATA <= 32'h00000000;
            endcase
        end
        else
            HRDATA <= 32'h00000000;
    end

    always_ff @(posedge CORE_CLK)
    begin
        if (!RSTN)
        begin
            HREADYOUT <= 1'b1;
            HRESP <= 1'b0;
            LOCK_LOST_FLAG <= 1'b1;
            INTERRUPT_OUT_N <= 1'b1;
        end
        else
        begin
            HREADYOUT <= 1'b1;
            HRESP <= 1'b0;
            LOCK_LOST_FLAG <= lol_reg;
            INTERRUPT_OUT_N <= ~|(sticky_reg & mask_reg);
        end
    end
endmodule : isfm_top

// ### verilog/isfm_pkg.sv
// constants, types and helper functions for the input select and fault monitor
// Summary of operation
// - manual choice comes from select pins or a register field; pins by default
// - select code 0..3 picks input 0..3; code 3 selects nothing in zero-delay mode
// - a manually chosen input without clock drops the loop into free-run or holdover
// - in zero-delay mode input 3 is the feedback input and never a reference
// - automatic mode picks only valid inputs; none valid means free-run or holdover
// - revertive: always hold the best valid input, switch when a better one appears
// - non-revertive: keep the active input while valid, then take the best valid
// - hitless switching lets the loop absorb phase steps; supports inputs to 8 kHz
// - ramped switching shares the holdover-exit ramp setting
// - switches up to 500 ppm are smooth; lock lost stays up during pull-in
// - gapped inputs of 10 MHz or more, two of eight missing, raise no fault
// - all four inputs watched for signal loss and frequency error; crystal for loss
// - signal loss measures every period; sensitivity tolerates isolated missing edges
// - each signal-loss monitor has live and sticky bits and its own disable
// - reference signal loss disables output clocks unless configured to keep them
// - frequency-error zero-ppm reference is the crystal or any one input
// - frequency error merges a precise and a fast monitor, each disableable
// - precise monitor window up to 500 ppm in 1/16 ppm steps with hysteresis
// - fast monitor flags a frequency move beyond 4000 ppm
// - lock lost set and cleared by two thresholds from 0.1 to 10000 ppm
// - optional timer delays clearing of lock lost
// - lock-lost pin follows the monitor; live and sticky bits kept as well
// - active-low interrupt on masked status events, released when sticky cleared
package isfm_pkg;
    localparam int ISFM_NUM_IN = 4;
    localparam int ISFM_NUM_MON = 5;
    localparam int ISFM_XREF_IDX = 4;
    localparam int ISFM_CNT_W = 16;
    localparam int ISFM_TOL_W = 4;
    localparam int ISFM_LIM_W = 22;
    localparam int ISFM_PROD_W = 48;
    localparam int ISFM_WIN_W = 13;
    localparam int ISFM_THR_W = 17;
    localparam int ISFM_TMR_W = 16;
    localparam int ISFM_PRIO_W = 2;
    localparam int ISFM_STAT_W = 11;
    localparam logic [ISFM_CNT_W-1:0] ISFM_CNT_MAX = 16'hFFFF;
    localparam logic [ISFM_LIM_W-1:0] ISFM_TOL_BASE = 22'h000002;
    localparam logic [ISFM_TOL_W-1:0] ISFM_GAP_TOL = 4'h2;
    localparam logic [11:0] ISFM_WIN_LAST = 12'hFFF;
    localparam longint ISFM_PPM_SCALE = 1000000;
    localparam longint ISFM_PREC_STEPS = 16;
    localparam longint ISFM_FAST_PPM = 4000;
    localparam logic [ISFM_PROD_W-1:0] ISFM_PREC_SCALE = ISFM_PROD_W'(ISFM_PPM_SCALE * ISFM_PREC_STEPS);
    localparam logic [ISFM_PROD_W-1:0] ISFM_FAST_SCALE = ISFM_PROD_W'(ISFM_PPM_SCALE);
    localparam logic [ISFM_PROD_W-1:0] ISFM_FAST_LIM = ISFM_PROD_W'(ISFM_FAST_PPM);
    localparam logic [1:0] ISFM_CODE_FB = 2'h3;
    localparam logic [2:0] ISFM_REF_XTAL = 3'h4;
    // register word indexes (byte address = 4 * index)
    localparam logic [5:0] ISFM_R_CTRL = 6'h00;
    localparam logic [5:0] ISFM_R_MONDIS = 6'h01;
    localparam logic [5:0] ISFM_R_PRIO = 6'h02;
    localparam logic [5:0] ISFM_R_LOSSENS = 6'h03;
    localparam logic [5:0] ISFM_R_FWIN = 6'h04;
    localparam logic [5:0] ISFM_R_LSET = 6'h05;
    localparam logic [5:0] ISFM_R_LCLR = 6'h06;
    localparam logic [5:0] ISFM_R_LTMR = 6'h07;
    localparam logic [5:0] ISFM_R_LIVE = 6'h08;
    localparam logic [5:0] ISFM_R_STICKY = 6'h09;
    localparam logic [5:0] ISFM_R_MASK = 6'h0A;
    localparam logic [7:0] ISFM_PRIO_RST = 8'hE4;
    // status bit positions, then monitor-disable bits and the hysteresis field offset
    localparam int ISFM_S_LOSS = 0;
    localparam int ISFM_S_XLOSS = 4;
    localparam int ISFM_S_FERR = 5;
    localparam int ISFM_S_LOL = 9;
    localparam int ISFM_S_HOLD = 10;
    localparam int ISFM_S_SEL = 12;
    localparam int ISFM_S_SELV = 14;
    localparam int ISFM_MD_FAST = 6;
    localparam int ISFM_MD_PREC = 5;
    localparam int ISFM_FW_HYS = 16;

    typedef struct packed {
        logic gapped;
        logic [2:0] ferr_ref;
        logic keep_out;
        logic ramp;
        logic hitless;
        logic zero_delay;
        logic revertive;
        logic auto_mode;
        logic [1:0] man_code;
        logic sel_from_reg;
    } isfm_cfg_t;

    typedef enum logic [1:0] {
        ISFM_FREERUN = 2'b00,
        ISFM_LOCKED = 2'b01,
        ISFM_HOLDOVER = 2'b10
    } isfm_state_t;

    function automatic logic [ISFM_CNT_W-1:0] isfm_abs_diff(
        input logic [ISFM_CNT_W-1:0] a,
        input logic [ISFM_CNT_W-1:0] b
    );
        return (a > b) ? a - b : b - a;
    endfunction : isfm_abs_diff

    // returns {found, index}; slot 0 of the table is the highest priority
    function automatic logic [2:0] isfm_pick_best(
        input logic [ISFM_NUM_IN-1:0] valid,
        input logic [2*ISFM_PRIO_W+3:0] prio
    );
        logic [2:0] pick;
        pick = 3'h0;
        for (int k = ISFM_NUM_IN - 1; k >= 0; k--)
        begin
            if (valid[prio[ISFM_PRIO_W*k +: ISFM_PRIO_W]])
                pick = {1'b1, prio[ISFM_PRIO_W*k +: ISFM_PRIO_W]};
        end
        return pick;
    endfunction : isfm_pick_best
endpackage : isfm_pkg

// ### verilog/isfm_clk_mon.sv
// per-clock period and edge-count monitor sampled on the core clock
`timescale 1ns/10ps
module isfm_clk_mon
    import isfm_pkg::*;
(
    input wire logic clk,
    input wire logic rstn,
    input wire logic clk_pin,
    input wire logic mon_en,
    input wire logic [ISFM_TOL_W-1:0] tol,
    input wire logic win_tick,
    output logic loss,
    output logic [ISFM_CNT_W-1:0] freq_cnt
);
    logic [2:0] sync_reg;
    logic [ISFM_CNT_W-1:0] gap_cnt_reg;
    logic [ISFM_CNT_W-1:0] period_reg;
    logic [ISFM_CNT_W-1:0] edge_cnt_reg;
    logic [ISFM_LIM_W-1:0] limit;
    logic rise;

    // stage 0 feeds only stage 1; the edge detector looks at stages 1 and 2
    always_ff @(posedge clk)
    begin
        if (!rstn)
            sync_reg <= 3'h0;
        else
            sync_reg <= {sync_reg[1:0], clk_pin};
    end

    assign rise = sync_reg[1] & ~sync_reg[2];
    // tolerate up to tol+1 consecutive missing edges before flagging
    assign limit = ISFM_LIM_W'(period_reg) * (ISFM_LIM_W'(tol) + ISFM_TOL_BASE);

    always_ff @(posedge clk)
    begin
        if (!rstn)
            gap_cnt_reg <= '0;
        else if (rise)
            gap_cnt_reg <= '0;
        else if (gap_cnt_reg != ISFM_CNT_MAX)
            gap_cnt_reg <= gap_cnt_reg + 1'b1;
    end

    // every unsaturated interval is learned so a flagged clock re-learns; a saturated count would wrap
    always_ff @(posedge clk)
    begin
        if (!rstn)
            period_reg <= '0;
        else if (rise && gap_cnt_reg != ISFM_CNT_MAX)
            period_reg <= gap_cnt_reg + 1'b1;
    end

    always_ff @(posedge clk)
    begin
        if (!rstn)
            loss <= 1'b1;
        else if (!mon_en)
            loss <= 1'b0;
        else if (rise)
            loss <= 1'b0;
        else if (gap_cnt_reg == ISFM_CNT_MAX || ISFM_LIM_W'(gap_cnt_reg) > limit)
            loss <= 1'b1;
    end

    always_ff @(posedge clk)
    begin
        if (!rstn)
        begin
            edge_cnt_reg <= '0;
            freq_cnt <= '0;
        end
        else if (win_tick)
        begin
            edge_cnt_reg <= '0;
            freq_cnt <= edge_cnt_reg + ISFM_CNT_W'(rise);
        end
        else if (rise)
            edge_cnt_reg <= edge_cnt_reg + 1'b1;
    end
endmodule : isfm_clk_mon

// ### testbench/isfm_src.sv
// clock sources standing in for the four inputs and the crystal
`timescale 1ns/10ps
module isfm_src (
    input wire logic [4:0] run,
    output logic [3:0] in_clk,
    output logic xtal
);
    logic [4:0] ph = 5'h00;
    // a stopped source holds its level, as a dead clock does; 2 MHz keeps it sampleable
    always #250 ph = ph ^ run;
    assign in_clk = ph[3:0];
    assign xtal = ph[4];
endmodule : isfm_src

// ### testbench/isfm_properties.sv
// bound property checker for the input select and fault monitor
`timescale 1ns/10ps
module isfm_properties
    import isfm_pkg::*;
(
    input wire logic CORE_CLK,
    input wire logic RSTN,
    input wire logic HSEL,
    input wire logic [1:0] HTRANS,
    input wire logic HWRITE,
    input wire logic HREADY,
    input wire logic [31:0] HRDATA,
    input wire logic HREADYOUT,
    input wire logic HRESP,
    input wire logic [1:0] SEL_INPUT,
    input wire logic SEL_VALID,
    input wire logic HOLDOVER,
    input wire logic SWITCH_PULSE,
    input wire logic LOCK_LOST_FLAG
);
    default clocking @(posedge CORE_CLK); endclocking
    default disable iff (!RSTN);
    chk_bus_okay: assert property (HREADYOUT && !HRESP)
        else $error("bus stall or error response");
    chk_rdata_idle: assert property (!$past(HSEL && HREADY && HTRANS[1] && !HWRITE) |->
        HRDATA == 32'h0) else $error("read data outside data phase");
    chk_lol_unlocked: assert property (!SEL_VALID [*2] |-> LOCK_LOST_FLAG)
        else $error("lock lost low while unlocked");
    chk_switch_lol: assert property (SWITCH_PULSE |-> ##[0:2] LOCK_LOST_FLAG)
        else $error("no lock lost after switch");
    chk_hold_excl: assert property (!(HOLDOVER && SEL_VALID))
        else $error("holdover while selected");
    chk_pulse_one: assert property (SWITCH_PULSE |=> !SWITCH_PULSE)
        else $error("switch pulse too long");
    chk_sel_change: assert property (SEL_VALID && $past(SEL_VALID) && $changed(SEL_INPUT)
        |-> SWITCH_PULSE || $past(SWITCH_PULSE)) else $error("silent switch");
    chk_lol_clear: assert property ($fell(LOCK_LOST_FLAG) |-> SEL_VALID)
        else $error("lock lost cleared while unlocked");
    chk_lock_start: assert property ($rose(SEL_VALID) |-> LOCK_LOST_FLAG)
        else $error("lock lost clear at lock start");
endmodule : isfm_properties
bind isfm_top isfm_properties u_chk (.*);

// ### testbench/isfm_top_bench.sv
// self-checking bench for the input select and fault monitor
`timescale 1ns/10ps
module isfm_top_bench
    import isfm_pkg::*;
;
    logic CORE_CLK = 1'h0, RSTN = 1'h0, HSEL = 1'h0, HWRITE = 1'h0, rd_dp = 1'h0;
    logic [1:0] HTRANS = '0, IN_SEL_PINS = '0, SEL_INPUT;
    logic [2:0] HSIZE = 3'h2;
    logic [31:0] HADDR = '0, HWDATA = '0, HRDATA, w;
    logic [16:0] LOCK_FREQ_DIFF = '0;
    logic [4:0] run = 5'h1F;
    logic [3:0] IN_CLK;
    logic HREADY, HREADYOUT, HRESP, SEL_VALID, HOLDOVER, SWITCH_PULSE, HITLESS_EN, RAMP_EN;
    logic OUT_CLK_EN, LOCK_LOST_FLAG, INTERRUPT_OUT_N, CRYSTAL_REFERENCE_INPUT;
    logic [31:0] eq[$], mq[$];
    int seed = 32'h3A5D20EE, mismatches = 0, n_tests = 0;
    isfm_src u_src (.run(run), .in_clk(IN_CLK), .xtal(CRYSTAL_REFERENCE_INPUT));
    isfm_top uut (.*);
    assign HREADY = HREADYOUT;
    initial forever #25 CORE_CLK = ~CORE_CLK;
    task automatic wrap_up();
        $display("checks %0d mismatches %0d", n_tests, mismatches);
        if (mismatches == 0 && n_tests > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask : wrap_up
    task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
        n_tests++;
        if (s !== e)
        begin
            mismatches++;
            $display("Error %s expected %h seen %h", n, e, s);
        end
    endtask : chk
    task automatic cyc(input int n);
        repeat (n) @(posedge CORE_CLK);
    endtask : cyc
    // one single word transfer; waits on ready in both phases
    task automatic bus(input logic wr, input logic [5:0] ix, input logic [31:0] d);
        HSEL <= 1'h1;
        HTRANS <= 2'h2;
        HWRITE <= wr;
        HADDR <= {24'h0, ix, 2'h0};
        do @(posedge CORE_CLK); while (HREADY !== 1'h1);
        HSEL <= 1'h0;
        HTRANS <= 2'h0;
        HWDATA <= d;
        do @(posedge CORE_CLK); while (HREADY !== 1'h1);
    endtask : bus
    task automatic rd(input logic [5:0] ix, input logic [31:0] e, input logic [31:0] m);
        eq.push_back(e & m);
        mq.push_back(m);
        bus(1'h0, ix, '0);
    endtask : rd
    always @(posedge CORE_CLK)
    begin
        if (rd_dp)
            chk("rdata", HRDATA & mq.pop_front(), eq.pop_front());
        rd_dp <= HSEL && HTRANS[1] && !HWRITE && HREADY;
    end
    initial
    begin
        #1000000;
        mismatches++;
        wrap_up();
    end
    initial
    begin
        cyc(12);
        RSTN <= 1'h1;
        cyc(1);
        rd(ISFM_R_CTRL, '0, '1);
        rd(ISFM_R_PRIO, 32'hE4, '1);
        w = $random(seed);
        bus(1'h1, ISFM_R_MASK, w);
        bus(1'h1, 6'h3F, w);
        rd(ISFM_R_MASK, w, 32'h7FF);
        rd(6'h3F, '0, '1);
        // frequency monitors off: equal-rate sources still differ by a count per window
        bus(1'h1, ISFM_R_MONDIS, 32'h60);
        bus(1'h1, ISFM_R_LCLR, 32'hA);
        bus(1'h1, ISFM_R_LSET, 32'h14);
        bus(1'h1, ISFM_R_LTMR, 32'h5);
        for (int c = 0; c < 4; c++)
        begin
            IN_SEL_PINS <= c[1:0];
            cyc(40);
            chk("sel", SEL_INPUT, c);
            chk("valid", SEL_VALID, 1);
        end
        LOCK_FREQ_DIFF <= 17'($random(seed) & 7);
        cyc(20);
        chk("lol", LOCK_LOST_FLAG, 0);
        LOCK_FREQ_DIFF <= 17'h1E;
        cyc(6);
        chk("lol", LOCK_LOST_FLAG, 1);
        LOCK_FREQ_DIFF <= 17'($random(seed) & 7);
        cyc(3);
        chk("lol", LOCK_LOST_FLAG, 1);
        cyc(10);
        chk("lol", LOCK_LOST_FLAG, 0);
        $display("manual and lock done");
        bus(1'h1, ISFM_R_CTRL, 32'h3);
        cyc(20);
        chk("sel", SEL_INPUT, 1);
        bus(1'h1, ISFM_R_CTRL, 32'hE7);
        cyc(20);
        chk("valid", SEL_VALID, 0);
        chk("hitless", HITLESS_EN, 0);
        chk("ramp", RAMP_EN, 1);
        bus(1'h1, ISFM_R_CTRL, 32'h43);
        bus(1'h1, ISFM_R_MASK, 32'h2);
        cyc(20);
        chk("hitless", HITLESS_EN, 1);
        bus(1'h1, ISFM_R_STICKY, 32'h7FF);
        run <= 5'h1D;
        cyc(60);
        chk("valid", SEL_VALID, 0);
        chk("irq", INTERRUPT_OUT_N, 0);
        rd(ISFM_R_LIVE, 32'h2, 32'h2);
        bus(1'h1, ISFM_R_STICKY, 32'h2);
        rd(ISFM_R_STICKY, 32'h2, 32'h2);
        run <= 5'h1F;
        cyc(20);
        bus(1'h1, ISFM_R_STICKY, 32'h2);
        cyc(3);
        chk("irq", INTERRUPT_OUT_N, 1);
        rd(ISFM_R_STICKY, '0, 32'h2);
        bus(1'h1, ISFM_R_MONDIS, 32'h62);
        run <= 5'h1D;
        cyc(60);
        chk("valid", SEL_VALID, 1);
        run <= 5'h1F;
        bus(1'h1, ISFM_R_MONDIS, 32'h60);
        $display("loss monitor done");
        bus(1'h1, ISFM_R_CTRL, 32'h18);
        for (int k = 0; k < 2; k++)
        begin
            cyc(40);
            chk("sel", SEL_INPUT, 0);
            run <= 5'h1E;
            cyc(60);
            chk("sel", SEL_INPUT, 1);
            run <= 5'h1F;
            cyc(40);
            chk("sel", SEL_INPUT, k);
            bus(1'h1, ISFM_R_CTRL, 32'h8);
        end
        run <= 5'h10;
        cyc(60);
        chk("hold", HOLDOVER, 1);
        run <= 5'h0F;
        cyc(60);
        chk("outen", OUT_CLK_EN, 0);
        bus(1'h1, ISFM_R_CTRL, 32'h108);
        cyc(5);
        chk("outen", OUT_CLK_EN, 1);
        $display("auto select done");
        wrap_up();
    end
endmodule : isfm_top_bench
